// [logic/isc_cond.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - each direct line drives its selected function
// - inversion swaps direct line on/off sense
// - on only after exceeding on dead-time
// - one-shot forces direct on off after 250us
// - direct line also asserts composite function
// - four independent virtual input channels
// - virtual channel picks one internal output source
// - active source asserts assigned function
// - virtual channels have inversion and dead-time
// - virtual one-shot forces off after 250us
// - virtual channels run alongside direct lines
module isc_cond
   import isc_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   input  wire logic [NUM_DIN-1:0]    din_pin,
   input  wire logic [NUM_SRC-1:0]    drv_out,
   output logic      [NUM_FUNC-1:0]   func_level,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr
);

   ////////////////////////////////////////////////////////////////////////////
   // configuration storage
   logic [31:0]          din_cfg [NUM_DIN];
   logic [31:0]          vin_cfg [NUM_VIN];
   logic [NUM_DIN-1:0]   pin_s1;
   logic [NUM_DIN-1:0]   pin_s2;
   logic [NUM_DIN-1:0]   pin_s3;
   logic [NUM_DIN-1:0]   pin_clean;
   logic [NUM_DIN-1:0]   din_on;
   logic [NUM_VIN-1:0]   vin_on;
   logic [TICK_CNT_W-1:0] tick_cnt;
   logic                 ms_tick;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire                  acc       = psel & penable;
   wire                  wr_acc    = acc & pwrite;
   wire                  in_din    = (paddr[11:6] == REG_DIN_BASE[11:6]) && (paddr[5:2] < NUM_DIN);
   wire                  in_vin    = (paddr[11:6] == REG_VIN_BASE[11:6]) && (paddr[5:2] < NUM_VIN);
   wire                  in_stat   = (paddr == REG_STAT);
   wire                  in_raw    = (paddr == REG_RAW);
   wire                  mapped    = (in_din | in_vin | in_stat | in_raw) && (paddr[1:0] == 2'h0);
   wire [DIN_W-1:0]      din_idx   = paddr[2+:DIN_W];
   wire [VIN_W-1:0]      vin_idx   = paddr[2+:VIN_W];
   wire [31:0]           stat_word = {{(32-NUM_DIN-NUM_VIN){1'b0}}, vin_on, din_on};
   wire [31:0]           raw_word  = {{(32-NUM_DIN){1'b0}}, pin_clean};
   wire [31:0]           next_prdata =
      !mapped ? 32'h0000_0000 :
      in_din  ? din_cfg[din_idx] :
      in_vin  ? vin_cfg[vin_idx] :
      in_stat ? stat_word : raw_word;

   // one-cycle access, answer in the access phase
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata  <= next_prdata;
      end
   end

   // configuration writes land at the completing edge
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < NUM_DIN; i++) din_cfg[i] <= CFG_RST;
         for (int i = 0; i < NUM_VIN; i++) vin_cfg[i] <= CFG_RST;
      end
      else if (wr_acc && pready && mapped)
      begin
         if (in_din) din_cfg[din_idx] <= pwdata;
         if (in_vin) vin_cfg[vin_idx] <= pwdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser, change taken when stages two and three agree
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1    <= '0;
         pin_s2    <= '0;
         pin_s3    <= '0;
         pin_clean <= '0;
      end
      else
      begin
         pin_s1 <= din_pin;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         for (int i = 0; i < NUM_DIN; i++)
            if (pin_s2[i] == pin_s3[i]) pin_clean[i] <= pin_s3[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // millisecond enable for the dead-time counters
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick_cnt <= '0;
         ms_tick  <= 1'b0;
      end
      else
      begin
         ms_tick  <= (tick_cnt == TICK_CNT_W'(TICK_CYC - 1));
         tick_cnt <= (tick_cnt == TICK_CNT_W'(TICK_CYC - 1)) ? '0 : tick_cnt + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // conditioning paths, direct lines then virtual channels
   logic [NUM_DIN-1:0]   din_raw;
   logic [NUM_VIN-1:0]   vin_raw;

   genvar g;
   generate
      for (g = 0; g < NUM_DIN; g++)
      begin : g_din
         assign din_raw[g] = pin_clean[g] ^ din_cfg[g][F_INV_BIT];
         isc_path u_path (
            .mclk    (mclk),
            .rst_n   (rst_n),
            .ms_tick (ms_tick),
            .raw     (din_raw[g]),
            .dead_ms (din_cfg[g][F_DEAD_LSB+:DEAD_W]),
            .one_sh  (din_cfg[g][F_OS_BIT]),
            .on      (din_on[g])
         );
      end
      // four channels in parallel with lines
      for (g = 0; g < NUM_VIN; g++)
      begin : g_vin
         assign vin_raw[g] = drv_out[vin_cfg[g][F_SRC_LSB+:SRC_W]] ^ vin_cfg[g][F_INV_BIT];
         isc_path u_path (
            .mclk    (mclk),
            .rst_n   (rst_n),
            .ms_tick (ms_tick),
            .raw     (vin_raw[g]),
            .dead_ms (vin_cfg[g][F_DEAD_LSB+:DEAD_W]),
            .one_sh  (vin_cfg[g][F_OS_BIT]),
            .on      (vin_on[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // function map, every path targeting a function is or-ed
   logic [NUM_FUNC-1:0]  next_func;

   always_comb
   begin
      next_func = '0;
      for (int i = 0; i < NUM_DIN; i++)
      begin
         if (din_on[i]) next_func[din_cfg[i][F_FUNC_LSB+:FUNC_W]] = 1'b1;
         if (din_on[i] && din_cfg[i][F_COMP_EN_BIT])
            next_func[din_cfg[i][F_COMP_LSB+:FUNC_W]] = 1'b1;
      end
      for (int i = 0; i < NUM_VIN; i++)
         if (vin_on[i]) next_func[vin_cfg[i][F_FUNC_LSB+:FUNC_W]] = 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n) func_level <= '0;
      else        func_level <= next_func;
   end

endmodule : isc_cond

////////////////////////////////////////////////////////////////////////////////
// one path: dead-time qualifier then optional one-shot
module isc_path
   import isc_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              ms_tick,
   input  wire logic              raw,
   input  wire logic [DEAD_W-1:0] dead_ms,
   input  wire logic              one_sh,
   output logic                   on
);

   logic [DEAD_W:0]       dead_cnt;
   logic                  qual;
   logic                  qual_d;
   logic [OS_CNT_W-1:0]   os_cnt;
   logic                  os_done;

   // on only after raw exceeds dead-time
   wire   over = (dead_ms == '0) || (dead_cnt > {1'b0, dead_ms});

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dead_cnt <= '0;
         qual     <= 1'b0;
         qual_d   <= 1'b0;
      end
      else
      begin
         qual_d <= qual;
         if (!raw)
         begin
            dead_cnt <= '0;
            qual     <= 1'b0;
         end
         else
         begin
            if (ms_tick && !dead_cnt[DEAD_W]) dead_cnt <= dead_cnt + 1'b1;
            qual <= over;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         os_cnt  <= '0;
         os_done <= 1'b0;
      end
      else if (!qual)
      begin
         os_cnt  <= '0;
         os_done <= 1'b0;
      end
      else if (qual && !qual_d)
         os_cnt <= OS_CNT_W'(1);
      else if (os_cnt == OS_CNT_W'(ONE_SHOT_CYC))
         os_done <= 1'b1;
      else
         os_cnt <= os_cnt + 1'b1;
   end

   assign on = qual & ~(one_sh & os_done);

endmodule : isc_path

// [common/isc_pkg.sv]
package isc_pkg;

   // system clock
   localparam int unsigned CLK_HZ           = 20000000;
   localparam int unsigned CLK_PERIOD_NS    = 50;

   // counts of paths and functions
   localparam int unsigned NUM_DIN          = 6;
   localparam int unsigned NUM_VIN          = 4;
   localparam int unsigned NUM_SRC          = 32;
   localparam int unsigned NUM_FUNC         = 64;
   localparam int unsigned FUNC_W           = 6;
   localparam int unsigned SRC_W            = 5;
   localparam int unsigned DIN_W            = 3;
   localparam int unsigned VIN_W            = 2;

   // one-shot width and dead-time unit
   localparam int unsigned ONE_SHOT_US      = 250;
   localparam int unsigned ONE_SHOT_CYC     = (ONE_SHOT_US * (CLK_HZ / 1000000));
   localparam int unsigned TICK_MS_US       = 1000;
   localparam int unsigned TICK_CYC         = (TICK_MS_US * (CLK_HZ / 1000000));
   localparam int unsigned DEAD_MAX_MS      = 250;
   localparam int unsigned DEAD_W           = 8;
   localparam int unsigned OS_CNT_W         = 13;
   localparam int unsigned TICK_CNT_W       = 15;

   // apb register map, one word per register
   localparam logic [11:0] REG_DIN_BASE     = 12'h000;
   localparam logic [11:0] REG_VIN_BASE     = 12'h040;
   localparam logic [11:0] REG_STAT         = 12'h080;
   localparam logic [11:0] REG_RAW          = 12'h084;

   // per-path configuration word layout
   localparam int unsigned F_FUNC_LSB       = 0;
   localparam int unsigned F_COMP_LSB       = 8;
   localparam int unsigned F_SRC_LSB        = 8;
   localparam int unsigned F_INV_BIT        = 16;
   localparam int unsigned F_OS_BIT         = 17;
   localparam int unsigned F_COMP_EN_BIT    = 18;
   localparam int unsigned F_DEAD_LSB       = 24;

   // reset values of the configuration words
   localparam logic [31:0] CFG_RST          = 32'h0000_0000;

endpackage : isc_pkg

// [verif/isc_cond_properties.sv]
`timescale 1ns/1ps
module isc_chk
   import isc_pkg::*;
(
   input wire logic                mclk,
   input wire logic                rst_n,
   input wire logic [NUM_FUNC-1:0] func_level,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // setup phase of a bus transfer
   wire setup = psel && !penable;
   a_ready_setup: assert property (setup |=> pready)
      else $error("no pready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_no_stray: assert property (!setup |=> !pready)
      else $error("pready without setup");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_err_data: assert property (pslverr |-> prdata == 32'h0000_0000)
      else $error("refused read with data");
   a_misalign_err: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
      else $error("misaligned access accepted");
   a_fifth_vin: assert property (setup && paddr == 12'h050 |=> pslverr)
      else $error("fifth virtual channel accepted");
   a_stat_ok: assert property (setup && paddr == 12'h080 |=> !pslverr)
      else $error("status read refused");
   a_reset_quiet: assert property ($rose(rst_n) |-> func_level == '0)
      else $error("function level after reset");
endmodule : isc_chk
bind isc_cond isc_chk i_isc_chk (.mclk(mclk), .rst_n(rst_n), .func_level(func_level), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// [verif/isc_host_wiring.sv]
`timescale 1ns/1ps
module isc_host_wiring
   import isc_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic [NUM_DIN-1:0] want,
   output logic      [NUM_DIN-1:0] din_pin
);
   // host switches its lines one edge after it decides
   always_ff @(posedge mclk)
   begin
      din_pin <= want;
   end
endmodule : isc_host_wiring

// [verif/tb_input_signal_conditioning.sv]
`timescale 1ns/1ps
module tb_input_signal_conditioning;
   import isc_pkg::*;
   logic                mclk, rst_n, psel, penable, pwrite, pready, pslverr, er;
   logic [NUM_DIN-1:0]  want, din_pin;
   logic [NUM_SRC-1:0]  drv_out;
   logic [NUM_FUNC-1:0] func_level;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata, rd;
   int                  err_total, checks;
   isc_host_wiring i_isc_host_wiring (.mclk(mclk), .want(want), .din_pin(din_pin));
   isc_cond i_isc_cond (.mclk(mclk), .rst_n(rst_n), .din_pin(din_pin), .drv_out(drv_out),
      .func_level(func_level), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // free-running clock
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task report_and_stop;
      if (err_total == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   task cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : cmp
   task fn(input int i, input logic e);
      cmp($sformatf("func_level[%0d]", i), {63'h0, e}, {63'h0, func_level[i]});
   endtask : fn
   // one bus transfer, answer taken at the edge where pready is high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      // setup phase starts just after a rising edge
      @(posedge mclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // pready, prdata and pslverr are read at the rising edge that completes the access
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 20)
      begin
         err_total++;
         report_and_stop();
      end
   endtask : apb
   task wt(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : wt
   task drive(input logic [5:0] p, input logic [31:0] s);
      @(posedge mclk);
      want <= p; drv_out <= s;
   endtask : drive
   ////////////////////////////////////////////////////////////////////////////////
   task s_direct;
      apb(1'b1, 12'h000, 32'h0004_0905);
      apb(1'b1, 12'h004, 32'h0001_0007);
      wt(10);
      fn(7, 1'b1);
      drive(6'h03, 32'h0);
      wt(10);
      fn(5, 1'b1);
      fn(9, 1'b1);
      fn(7, 1'b0);
      apb(1'b0, 12'h080, 32'h0);
      cmp("status", 64'h1, {54'h0, rd[9:0]});
      apb(1'b0, 12'h000, 32'h0);
      cmp("din0 cfg", 64'h0004_0905, {32'h0, rd});
      apb(1'b0, 12'h082, 32'h0);
      cmp("misaligned pslverr", 64'h1, {63'h0, er});
      drive(6'h00, 32'h0);
      apb(1'b1, 12'h004, 32'h0);
      wt(10);
      fn(5, 1'b0);
   endtask : s_direct
   task s_virtual;
      for (int i = 0; i < 4; i++) apb(1'b1, 12'(12'h040 + 4 * i), 32'(((i + 3) << 8) | (20 + i)));
      drive(6'h01, 32'h28);
      wt(10);
      for (int i = 0; i < 4; i++) fn(20 + i, i == 0 || i == 2);
      fn(5, 1'b1);
      drive(6'h00, 32'h78);
      wt(4);
      for (int i = 0; i < 4; i++) fn(20 + i, 1'b1);
      apb(1'b0, 12'h050, 32'h0);
      cmp("pslverr", 64'h1, {63'h0, er});
      drive(6'h00, 32'h0);
   endtask : s_virtual
   task s_oneshot;
      apb(1'b1, 12'h008, 32'h0002_001f);
      apb(1'b1, 12'h040, 32'h0002_011e);
      drive(6'h04, 32'h2);
      wt(20);
      fn(31, 1'b1);
      fn(30, 1'b1);
      wt(5000);
      fn(31, 1'b0);
      fn(30, 1'b0);
      drive(6'h00, 32'h0);
   endtask : s_oneshot
   task s_dead;
      apb(1'b1, 12'h00c, 32'h0100_0028);
      apb(1'b1, 12'h044, 32'h0101_0229);
      drive(6'h08, 32'h0);
      wt(5000);
      fn(40, 1'b0);
      drive(6'h00, 32'h0);
      wt(9000);
      fn(40, 1'b0);
      fn(41, 1'b0);
      drive(6'h08, 32'h0);
      wt(45000);
      fn(40, 1'b1);
      fn(41, 1'b1);
   endtask : s_dead
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      err_total = 0; checks = 0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; want = 6'h00; drv_out = 32'h0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      s_direct();
      s_virtual();
      s_oneshot();
      s_dead();
      report_and_stop();
   end
endmodule : tb_input_signal_conditioning
